// ### include/upd_consts.svh
`ifndef UPD_CONSTS_SVH
`define UPD_CONSTS_SVH
// oversampling: sixteen ticks per bit, last index and mid-bit index
`define UPD_OS_LAST 4'hf
`define UPD_OS_MID 4'h7
// a zero divisor stands for 65536
`define UPD_DIV_ZERO 17'h10000
`define UPD_DIV_ONE 17'h00001
// parity mode encodings
`define UPD_PAR_NONE 2'h0
`define UPD_PAR_EVEN 2'h1
`define UPD_PAR_ODD 2'h2
// word length code for eight data bits; five bits is code zero
`define UPD_WLEN_8 2'h3
`define UPD_WLEN_BASE 3'h4
// buffer depth of each two-entry stage
`define UPD_BUF_FULL 2'h2
// dma arbitration level reported for both channels, lowest
`define UPD_DMA_PRIO_LOW 2'h0
`endif

// ### include/upd_pkg.sv
`include "upd_consts.svh"
package upd_pkg;

  // ********
  // frame engine types
  // ********
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_EXTRA = 5'b01000,
    TX_STOP = 5'b10000
  } upd_tx_st_type;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_EXTRA = 5'b01000,
    RX_STOP = 5'b10000
  } upd_rx_st_type;

  // line format shared by both directions
  typedef struct packed {
    logic [1:0] wlen;
    logic stop2;
    logic [1:0] par;
    logic addr_mode;
  } upd_cfg_type;

  typedef struct packed {
    upd_tx_st_type st;
    logic [16:0] cnt;
    logic [3:0] os;
    logic [2:0] idx;
    logic [8:0] sh;
    logic line;
  } upd_tx_type;

  typedef struct packed {
    upd_rx_st_type st;
    logic [16:0] cnt;
    logic [3:0] os;
    logic [2:0] idx;
    logic [8:0] sh;
    logic done;
    logic perr;
    logic ferr;
  } upd_rx_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } upd_sync_type;

  // whole state of the device end
  typedef struct packed {
    upd_tx_type tx;
    upd_rx_type rx;
    upd_sync_type sy;
    logic [1:0][8:0] tb;
    logic [1:0] tcnt;
    logic [1:0][8:0] rb;
    logic [1:0] rcnt;
    logic listen;
    logic tx_rdy;
    logic dma_tx_req;
    logic rx_val;
    logic dma_rx_req;
    logic tx_irq;
    logic rx_irq;
    logic perr;
    logic ferr;
    logic ovr;
    logic [1:0] prio;
  } upd_dev_type;

  // whole state of the remote end
  typedef struct packed {
    upd_tx_type tx;
    upd_rx_type rx;
    upd_sync_type sy;
    logic [8:0] rdata;
    logic rval;
    logic perr;
    logic ferr;
    logic sready;
  } upd_rem_type;

  // ********
  // shared helpers
  // ********
  // clocks per oversample tick, zero means the slowest rate
  function automatic logic [16:0] upd_divv(input logic [7:0] hi, input logic [7:0] lo);
    upd_divv = ({hi, lo} == 16'h0000) ? `UPD_DIV_ZERO : {1'b0, hi, lo};
  endfunction

  function automatic logic [7:0] upd_mask(input logic [1:0] wlen);
    upd_mask = 8'hff >> (`UPD_WLEN_8 - wlen);
  endfunction

  function automatic logic upd_has_extra(input upd_cfg_type c);
    upd_has_extra = c.addr_mode || (c.par != `UPD_PAR_NONE);
  endfunction

  // parity bit over the live data bits only
  function automatic logic upd_parity(input logic [7:0] d, input upd_cfg_type c);
    upd_parity = (^(d & upd_mask(c.wlen))) ^ (c.par == `UPD_PAR_ODD);
  endfunction

  // three stages; a change counts once stages two and three agree
  function automatic upd_sync_type upd_sync(input upd_sync_type s, input logic pin);
    upd_sync = s;
    upd_sync.s1 = pin;
    upd_sync.s2 = s.s1;
    upd_sync.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      upd_sync.filt = s.s3;
    end
  endfunction

  // ********
  // transmit frame step: start, data, parity or address bit, stops
  // ********
  function automatic upd_tx_type upd_tx_step(input upd_tx_type s, input logic go,
                                             input logic [8:0] d, input logic [16:0] divv,
                                             input upd_cfg_type c);
    upd_tx_type n;
    logic tick;
    n = s;
    tick = 1'b0;
    // each oversample tick lasts divv clocks
    if (s.st != TX_IDLE)
    begin
      if (s.cnt == `UPD_DIV_ONE)
      begin
        tick = 1'b1;
        n.cnt = divv;
      end
      else
      begin
        n.cnt = s.cnt - `UPD_DIV_ONE;
      end
    end
    case (s.st)
      TX_IDLE:
      begin
        n.line = 1'b1;
        if (go)
        begin
          n.st = TX_START;
          n.cnt = divv;
          n.os = 4'h0;
          n.idx = 3'h0;
          n.line = 1'b0;
          // ninth bit marks an address, else it is parity
          n.sh = {c.addr_mode ? d[8] : upd_parity(d[7:0], c), d[7:0] & upd_mask(c.wlen)};
        end
      end
      default:
      begin
        if (tick)
        begin
          n.os = s.os + 4'h1;
          if (s.os == `UPD_OS_LAST)
          begin
            case (s.st)
              TX_START:
              begin
                n.st = TX_DATA;
                n.line = s.sh[0];
              end
              TX_DATA:
              begin
                // five to eight data bits
                if (s.idx == ({1'b0, c.wlen} + `UPD_WLEN_BASE))
                begin
                  n.idx = 3'h0;
                  n.st = upd_has_extra(c) ? TX_EXTRA : TX_STOP;
                  n.line = upd_has_extra(c) ? s.sh[8] : 1'b1;
                end
                else
                begin
                  n.idx = s.idx + 3'h1;
                  n.line = s.sh[n.idx];
                end
              end
              TX_EXTRA:
              begin
                n.st = TX_STOP;
                n.line = 1'b1;
              end
              TX_STOP:
              begin
                // one or two stop bits
                if (c.stop2 && (s.idx == 3'h0))
                begin
                  n.idx = 3'h1;
                end
                else
                begin
                  n.st = TX_IDLE;
                end
              end
              default:
              begin
                n.st = TX_IDLE;
              end
            endcase
          end
        end
      end
    endcase
    upd_tx_step = n;
  endfunction

  // ********
  // receive frame step: mid-bit sampling at sixteen times the rate
  // ********
  function automatic upd_rx_type upd_rx_step(input upd_rx_type s, input logic line,
                                             input logic [16:0] divv, input upd_cfg_type c);
    upd_rx_type n;
    logic tick;
    logic smp;
    n = s;
    n.done = 1'b0;
    tick = 1'b0;
    if (s.st != RX_IDLE)
    begin
      if (s.cnt == `UPD_DIV_ONE)
      begin
        tick = 1'b1;
        n.cnt = divv;
      end
      else
      begin
        n.cnt = s.cnt - `UPD_DIV_ONE;
      end
    end
    // mid of start bit, then every sixteen ticks
    smp = tick && (((s.st == RX_START) && (s.os == `UPD_OS_MID)) || (s.os == `UPD_OS_LAST));
    if (tick)
    begin
      n.os = smp ? 4'h0 : s.os + 4'h1;
    end
    case (s.st)
      RX_IDLE:
      begin
        if (!line)
        begin
          n.st = RX_START;
          n.cnt = divv;
          n.os = 4'h0;
          n.idx = 3'h0;
          n.perr = 1'b0;
          n.ferr = 1'b0;
        end
      end
      RX_START:
      begin
        // a start shorter than half a bit is noise
        if (smp)
        begin
          n.st = line ? RX_IDLE : RX_DATA;
          n.sh = 9'h000;
        end
      end
      RX_DATA:
      begin
        if (smp)
        begin
          n.sh[s.idx] = line;
          if (s.idx == ({1'b0, c.wlen} + `UPD_WLEN_BASE))
          begin
            n.idx = 3'h0;
            n.st = upd_has_extra(c) ? RX_EXTRA : RX_STOP;
          end
          else
          begin
            n.idx = s.idx + 3'h1;
          end
        end
      end
      RX_EXTRA:
      begin
        if (smp)
        begin
          n.sh[8] = line;
          n.perr = !c.addr_mode && (c.par != `UPD_PAR_NONE) && (line != upd_parity(s.sh[7:0], c));
          n.st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (smp)
        begin
          n.ferr = s.ferr | !line;
          if (c.stop2 && (s.idx == 3'h0))
          begin
            n.idx = 3'h1;
          end
          else
          begin
            n.st = RX_IDLE;
            n.done = 1'b1;
          end
        end
      end
      default:
      begin
        n.st = RX_IDLE;
      end
    endcase
    upd_rx_step = n;
  endfunction

endpackage

// ### include/upd_if.sv
`timescale 1ns/10ps
`default_nettype none
// two serial data lines, one per direction; idle level is high
interface upd_if;
  logic dev_txd;
  logic rem_txd;
  modport dev_mp (output dev_txd, input rem_txd);
  modport rem_mp (output rem_txd, input dev_txd);
endinterface
`default_nettype wire

// ### rtl/upd_device.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - transmit and receive run at the same time
// - ninth bit marks address characters on multidrop
// - five to eight data bits per character
// - one or two stop bits
// - parity none, even or odd, generated and checked
// - programmed transfers, two buffer stages each way
// - dma mode uses one transmit, one receive channel
// - both dma channels report low arbitration priority
// - bit rate from clock/1048576 up to clock/16
// - divisor is high byte over low byte
// - frame holds seven to twelve bits
// - transmit and receive requests, each maskable
// - filtered receive line offered to a timer
module upd_device (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  upd_if.dev_mp link,
  input wire logic [7:0] divisor_high_byte_i,
  input wire logic [7:0] divisor_low_byte_i,
  input wire logic [1:0] word_len_i,
  input wire logic two_stop_i,
  input wire logic [1:0] parity_mode_i,
  input wire logic addr_mode_i,
  input wire logic [7:0] own_addr_i,
  input wire logic dma_mode_i,
  input wire logic tx_irq_mask_i,
  input wire logic rx_irq_mask_i,
  input wire logic [8:0] tx_data_i,
  input wire logic pio_tx_valid_i,
  output logic pio_tx_ready_o,
  output logic dma_tx_req_o,
  input wire logic dma_tx_ack_i,
  output logic [8:0] rx_data_o,
  output logic pio_rx_valid_o,
  input wire logic pio_rx_read_i,
  output logic dma_rx_req_o,
  input wire logic dma_rx_ack_i,
  output logic rx_parity_err_o,
  output logic rx_frame_err_o,
  output logic rx_overrun_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic [1:0] dma_prio_o,
  output logic autobaud_rx_o
);
  import upd_pkg::*;

  // ********
  // state and decode nets
  // ********
  upd_dev_type q; // registered state
  upd_dev_type d; // next state
  upd_cfg_type cfg; // line format
  logic [16:0] divv; // clocks per oversample tick
  logic tx_push; // word enters transmit buffer
  logic tx_pop; // word leaves for the shifter
  logic rx_pop; // word taken by software or dma
  logic rx_is_addr; // received character is an address
  logic rx_match; // address equals our own
  logic rx_keep; // received character is for us

  assign cfg = {word_len_i, two_stop_i, parity_mode_i, addr_mode_i};
  // 16 x divisor clocks per bit; slowest with zero divisor
  assign divv = upd_divv(divisor_high_byte_i, divisor_low_byte_i);

  // ********
  // next-state logic
  // ********
  // both directions are stepped every cycle, independently
  always_comb
  begin
    d = q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_pop = 1'b0;
    rx_is_addr = 1'b0;
    rx_match = 1'b0;
    rx_keep = 1'b0;
    // receive pin through three flops; the filtered level feeds the timer
    d.sy = upd_sync(q.sy, link.rem_txd);

    // transmit buffer fill: programmed writes or dma acks
    if (dma_mode_i)
    begin
      tx_push = q.dma_tx_req && dma_tx_ack_i;
    end
    else
    begin
      tx_push = q.tx_rdy && pio_tx_valid_i;
    end
    // the shifter only takes a word when idle; a full buffer stalls the writer
    tx_pop = (q.tx.st == TX_IDLE) && (q.tcnt != 2'h0);
    d.tx = upd_tx_step(q.tx, tx_pop, q.tb[0], divv, cfg);
    if (tx_pop)
    begin
      d.tb[0] = q.tb[1];
      d.tcnt = q.tcnt - 2'h1;
    end
    if (tx_push)
    begin
      d.tb[d.tcnt[0]] = tx_data_i; // first free stage of the double buffer
      d.tcnt = d.tcnt + 2'h1;
    end

    // receive frame engine runs on the filtered pin level
    d.rx = upd_rx_step(q.rx, q.sy.filt, divv, cfg);
    if (dma_mode_i)
    begin
      rx_pop = q.dma_rx_req && dma_rx_ack_i;
    end
    else
    begin
      rx_pop = q.rx_val && pio_rx_read_i;
    end
    if (rx_pop)
    begin
      d.rb[0] = q.rb[1];
      d.rcnt = q.rcnt - 2'h1;
    end

    // multidrop filter: address characters open or close the gate
    rx_is_addr = cfg.addr_mode && q.rx.sh[8];
    rx_match = (q.rx.sh[7:0] == own_addr_i);
    if (!cfg.addr_mode)
    begin
      rx_keep = 1'b1;
    end
    else if (rx_is_addr)
    begin
      rx_keep = rx_match;
    end
    else
    begin
      rx_keep = q.listen;
    end
    d.perr = 1'b0;
    d.ferr = 1'b0;
    d.ovr = 1'b0;
    if (q.rx.done)
    begin
      if (rx_is_addr)
      begin
        d.listen = rx_match;
      end
      if (rx_keep)
      begin
        // status pulses travel with the character they belong to
        d.perr = q.rx.perr;
        d.ferr = q.rx.ferr;
        if (d.rcnt == `UPD_BUF_FULL)
        begin
          // the line cannot be stalled, so a third word is dropped and flagged
          d.ovr = 1'b1;
        end
        else
        begin
          d.rb[d.rcnt[0]] = q.rx.sh;
          d.rcnt = d.rcnt + 2'h1;
        end
      end
    end

    // handshake outputs follow the mode select
    d.tx_rdy = !dma_mode_i && (d.tcnt != `UPD_BUF_FULL);
    d.dma_tx_req = dma_mode_i && (d.tcnt != `UPD_BUF_FULL);
    d.rx_val = !dma_mode_i && (d.rcnt != 2'h0);
    d.dma_rx_req = dma_mode_i && (d.rcnt != 2'h0);
    // requests only in programmed mode; dma mode needs no per-word service
    d.tx_irq = tx_irq_mask_i && !dma_mode_i && (d.tcnt != `UPD_BUF_FULL);
    d.rx_irq = rx_irq_mask_i && !dma_mode_i && (d.rcnt != 2'h0);
    // low service rate, so the channels sit below the others
    d.prio = `UPD_DMA_PRIO_LOW;
  end

  // ********
  // state register
  // ********
  // idle line and idle synchroniser are high after reset
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.tx.st <= TX_IDLE;
      q.tx.line <= 1'b1;
      q.rx.st <= RX_IDLE;
      q.sy <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  // ********
  // outputs, each straight from the state register
  // ********
  assign link.dev_txd = q.tx.line;
  assign pio_tx_ready_o = q.tx_rdy;
  assign dma_tx_req_o = q.dma_tx_req;
  assign rx_data_o = q.rb[0];
  assign pio_rx_valid_o = q.rx_val;
  assign dma_rx_req_o = q.dma_rx_req;
  assign rx_parity_err_o = q.perr;
  assign rx_frame_err_o = q.ferr;
  assign rx_overrun_o = q.ovr;
  assign tx_irq_o = q.tx_irq;
  assign rx_irq_o = q.rx_irq;
  assign dma_prio_o = q.prio;
  assign autobaud_rx_o = q.sy.filt;
endmodule
`default_nettype wire

// ### rtl/upd_remote.sv
`timescale 1ns/10ps
`default_nettype none
// far station on the serial line: one word in flight each way
module upd_remote (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  upd_if.rem_mp link,
  input wire logic [7:0] divisor_high_byte_i,
  input wire logic [7:0] divisor_low_byte_i,
  input wire logic [1:0] word_len_i,
  input wire logic two_stop_i,
  input wire logic [1:0] parity_mode_i,
  input wire logic addr_mode_i,
  input wire logic [8:0] send_data_i,
  input wire logic send_valid_i,
  output logic send_ready_o,
  output logic [8:0] recv_data_o,
  output logic recv_valid_o,
  output logic recv_parity_err_o,
  output logic recv_frame_err_o
);
  import upd_pkg::*;

  upd_rem_type q; // registered state
  upd_rem_type d; // next state
  upd_cfg_type cfg; // line format, must match the device end
  logic [16:0] divv; // clocks per oversample tick

  assign cfg = {word_len_i, two_stop_i, parity_mode_i, addr_mode_i};
  assign divv = upd_divv(divisor_high_byte_i, divisor_low_byte_i);

  // ********
  // next-state logic
  // ********
  // send and receive step independently; no buffer, the sender just waits
  always_comb
  begin
    d = q;
    d.sy = upd_sync(q.sy, link.dev_txd);
    // bit 8 of a sent word is the address mark in address mode
    d.tx = upd_tx_step(q.tx, send_valid_i && q.sready, send_data_i, divv, cfg);
    d.sready = (d.tx.st == TX_IDLE);
    d.rx = upd_rx_step(q.rx, q.sy.filt, divv, cfg);
    d.rval = q.rx.done;
    d.perr = q.rx.done && q.rx.perr;
    d.ferr = q.rx.done && q.rx.ferr;
    if (q.rx.done)
    begin
      d.rdata = q.rx.sh;
    end
  end

  // ********
  // state register
  // ********
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.tx.st <= TX_IDLE;
      q.tx.line <= 1'b1;
      q.rx.st <= RX_IDLE;
      q.sy <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.rem_txd = q.tx.line;
  assign send_ready_o = q.sready;
  assign recv_data_o = q.rdata;
  assign recv_valid_o = q.rval;
  assign recv_parity_err_o = q.perr;
  assign recv_frame_err_o = q.ferr;
endmodule
`default_nettype wire

// ### verification/upd_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// watches both serial lines between the two ends
module upd_link_assertions (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic dev_txd,
  input wire logic rem_txd
);
  // ********
  // run lengths
  // ********
  // counters saturate so a long idle line never wraps into a short run
  logic [23:0] dlo_q;
  logic [23:0] dhi_q;
  logic [23:0] rlo_q;
  logic [23:0] rhi_q;

  function automatic logic [23:0] run_d(input logic [23:0] c, input logic on);
    run_d = !on ? 24'h000000 : (&c) ? c : c + 24'h000001;
  endfunction

  // high runs start at one whole bit so the first start after reset passes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      dlo_q <= 24'h000000;
      rlo_q <= 24'h000000;
      dhi_q <= 24'h000010;
      rhi_q <= 24'h000010;
    end
    else
    begin
      dlo_q <= run_d(dlo_q, !dev_txd);
      rlo_q <= run_d(rlo_q, !rem_txd);
      dhi_q <= run_d(dhi_q, dev_txd);
      rhi_q <= run_d(rhi_q, rem_txd);
    end
  end

  // ********
  // line properties
  // ********
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  dev_idle_reset_a: assert property ($fell(sys_rst_i) |-> dev_txd [*2])
    else $error("device line not idle after reset");
  rem_idle_reset_a: assert property ($fell(sys_rst_i) |-> rem_txd ##1 rem_txd)
    else $error("remote line not idle after reset");
  // a low run ends on a bit edge, so it is whole bits of sixteen ticks
  dev_bit_whole_a: assert property ($rose(dev_txd) && !$past(sys_rst_i) |-> dlo_q[3:0] == 4'h0)
    else $error("device low run not whole bits");
  dev_bit_min_a: assert property ($rose(dev_txd) && !$past(sys_rst_i) |-> dlo_q >= 24'h000010)
    else $error("device bit shorter than sixteen clocks");
  dev_stop_min_a: assert property ($fell(dev_txd) |-> dhi_q >= 24'h000010)
    else $error("device high run too short");
  dev_start_hold_a: assert property ($fell(dev_txd) |-> (!dev_txd) [*8] ##8 !dev_txd)
    else $error("device start bit cut short");
  rem_bit_whole_a: assert property ($rose(rem_txd) && !$past(sys_rst_i) |-> rlo_q[3:0] == 4'h0)
    else $error("remote low run not whole bits");
  rem_bit_min_a: assert property ($rose(rem_txd) && !$past(sys_rst_i) |-> rlo_q >= 24'h000010)
    else $error("remote bit shorter than sixteen clocks");
  rem_stop_min_a: assert property ($fell(rem_txd) |-> rhi_q >= 24'h000010)
    else $error("remote high run too short");

  dev_frame_c: cover property ($fell(dev_txd));
  rem_frame_c: cover property ($fell(rem_txd));
  duplex_c: cover property (!dev_txd && !rem_txd);
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ********
  // stimulus and observed signals
  // ********
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  // remote format copies differ from the device's only to inject faults
  logic [7:0] dh = 8'h00, dl = 8'h01, oa = 8'h5a;
  logic [1:0] wl = 2'h3, pm = 2'h0, wlr = 2'h3, pmr = 2'h0;
  logic st2 = 1'b0, am = 1'b0, dm = 1'b0, tm = 1'b0, rm = 1'b0;
  logic [8:0] td = 9'h000, sd = 9'h000, rd, cd;
  logic tv = 1'b0, ta = 1'b0, rr = 1'b0, ra = 1'b0, sv = 1'b0;
  logic [1:0] pr;
  logic tr, tq, rv, rq, pe, fe, ov, ti, ri, ab, sr, cv, cpe, cfe;
  int bad_count = 0, n_checks = 0, cyc = 0;
  upd_if lk();

  upd_device u_upd_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lk.dev_mp),
    .divisor_high_byte_i(dh), .divisor_low_byte_i(dl), .word_len_i(wl), .two_stop_i(st2),
    .parity_mode_i(pm), .addr_mode_i(am), .own_addr_i(oa), .dma_mode_i(dm),
    .tx_irq_mask_i(tm), .rx_irq_mask_i(rm), .tx_data_i(td), .pio_tx_valid_i(tv),
    .pio_tx_ready_o(tr), .dma_tx_req_o(tq), .dma_tx_ack_i(ta), .rx_data_o(rd),
    .pio_rx_valid_o(rv), .pio_rx_read_i(rr), .dma_rx_req_o(rq), .dma_rx_ack_i(ra),
    .rx_parity_err_o(pe), .rx_frame_err_o(fe), .rx_overrun_o(ov), .tx_irq_o(ti),
    .rx_irq_o(ri), .dma_prio_o(pr), .autobaud_rx_o(ab));
  upd_remote u_upd_remote (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lk.rem_mp),
    .divisor_high_byte_i(dh), .divisor_low_byte_i(dl), .word_len_i(wlr), .two_stop_i(st2),
    .parity_mode_i(pmr), .addr_mode_i(am), .send_data_i(sd), .send_valid_i(sv),
    .send_ready_o(sr), .recv_data_o(cd), .recv_valid_o(cv), .recv_parity_err_o(cpe),
    .recv_frame_err_o(cfe));
  upd_link_assertions u_upd_link_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .dev_txd(lk.dev_txd), .rem_txd(lk.rem_txd));

  always #5 clk_i = ~clk_i;

  // ********
  // shared tasks
  // ********
  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under this many cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // inputs move one nanosecond after the edge, never on it
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // word as it should arrive: live bits, then mark or parity bit
  function automatic logic [8:0] framed(input logic [8:0] w);
    logic [7:0] d;
    d = w[7:0] & (8'hff >> (2'h3 - wl));
    framed = {am ? w[8] : (pm != 2'h0) && ((^d) ^ (pm == 2'h2)), d};
  endfunction

  task automatic send_pio(input logic [8:0] w);
    step();
    td = w;
    tv = 1'b1;
    // ready as it stands now is what the next edge samples
    while (tr !== 1'b1) step();
    step();
    tv = 1'b0;
  endtask

  task automatic send_rem(input logic [8:0] w);
    step();
    sd = w;
    sv = 1'b1;
    while (sr !== 1'b1) step();
    step();
    sv = 1'b0;
  endtask

  task automatic get_pio(input logic [8:0] w);
    while (rv !== 1'b1) step();
    check(rd, framed(w));
    rr = 1'b1;
    step();
    rr = 1'b0;
    // one idle edge so a following read never re-raises the strobe at once
    step();
  endtask

  // status bits must stay low on a clean frame
  task automatic get_rem(input logic [8:0] w);
    while (cv !== 1'b1) step();
    check({cpe, cfe, 1'b0, cd[7:0]}, framed(w) & 9'h0ff);
    step();
  endtask

  // samples the device line at each mid-bit and compares bit by bit
  task automatic watch(input logic [8:0] w);
    logic [8:0] f;
    int i;
    f = framed(w);
    while (lk.dev_txd !== 1'b0) step();
    step(7);
    check(lk.dev_txd, 1'b0);
    for (i = 0; i < wl + 5; i++)
    begin
      step(16);
      check(lk.dev_txd, f[i]);
    end
    if (am || pm != 2'h0)
    begin
      step(16);
      check(lk.dev_txd, f[8]);
    end
    for (i = 0; i <= st2; i++)
    begin
      step(16);
      check(lk.dev_txd, 1'b1);
    end
  endtask

  // ********
  // scenarios
  // ********
  // every length, parity and stop count, both directions at once
  task automatic t_formats;
    logic [8:0] w;
    int k;
    for (k = 0; k < 24; k++)
    begin
      step(24);
      wl = k[1:0];
      wlr = k[1:0];
      st2 = k[2];
      pm = 2'(k / 8);
      pmr = 2'(k / 8);
      w = 9'h0a5 ^ 9'(k * 37);
      fork
        send_pio(w);
        watch(w);
        get_rem(w);
        begin
          send_rem(~w);
          get_pio(~w);
        end
      join
    end
  endtask

  // receive overrun with two words held, masks, then a transmit burst
  task automatic t_buffer;
    int k;
    tm = 1'b1;
    rm = 1'b1;
    step(24);
    check(ti, 1'b1);
    fork
      for (k = 0; k < 3; k++)
        send_rem(9'h030 + 9'(k));
      while (ov !== 1'b1) step();
    join
    check(ri, 1'b1);
    rm = 1'b0;
    step();
    check(ri, 1'b0);
    get_pio(9'h030);
    get_pio(9'h031);
    check(rv, 1'b0);
    fork
      for (int j = 0; j < 4; j++)
        send_pio(9'h0b0 + 9'(j));
      for (int m = 0; m < 4; m++)
        get_rem(9'h0b0 + 9'(m));
      while (ti !== 1'b0) step();
    join
  endtask

  task automatic t_dma;
    rm = 1'b1;
    dm = 1'b1;
    step(24);
    check({tr, ti, ri}, 3'h0);
    fork
      begin
        while (tq !== 1'b1) step();
        td = 9'h0c3;
        ta = 1'b1;
        step();
        ta = 1'b0;
      end
      get_rem(9'h0c3);
      begin
        send_rem(9'h05e);
        while (rq !== 1'b1) step();
        check(rd, framed(9'h05e));
        ra = 1'b1;
        step();
        ra = 1'b0;
        check(rq, 1'b0);
      end
    join
    step(24);
    dm = 1'b0;
  endtask

  // only the matching address and the data after it are kept
  task automatic t_addr;
    am = 1'b1;
    step(24);
    fork
      begin
        send_rem(9'h15a);
        send_rem(9'h022);
        send_rem(9'h133);
        send_rem(9'h011);
      end
      begin
        get_pio(9'h15a);
        get_pio(9'h022);
      end
      send_pio(9'h1c3);
      watch(9'h1c3);
      get_rem(9'h1c3);
    join
    // the foreign address must close the gate on the last data word
    step(220);
    check(rv, 1'b0);
    step(24);
    am = 1'b0;
  endtask

  // high byte over low byte: 0x0102 gives sixteen ticks of 258 clocks
  task automatic t_div;
    int n;
    n = 0;
    dh = 8'h01;
    dl = 8'h02;
    wl = 2'h0;
    wlr = 2'h0;
    st2 = 1'b0;
    pm = 2'h0;
    pmr = 2'h0;
    fork
      send_pio(9'h001);
      get_rem(9'h001);
      begin
        while (lk.dev_txd !== 1'b0) step();
        while (lk.dev_txd === 1'b0)
        begin
          n++;
          step();
        end
      end
    join
    check(16'(n), 16'h1020);
    // let the slow stop bit finish before the divisor moves
    step(2100);
    dh = 8'h00;
    dl = 8'h01;
  endtask

  // remote breaks the format: wrong parity sense, then a too long word
  task automatic t_fault;
    step(24);
    pm = 2'h1;
    pmr = 2'h2;
    fork
      send_rem(9'h001);
      while (pe !== 1'b1) step();
    join
    check(rd, 9'h001);
    step(24);
    pm = 2'h0;
    pmr = 2'h0;
    wlr = 2'h3;
    fork
      send_rem(9'h0c0);
      while (fe !== 1'b1) step();
    join
    check(ov, 1'b0);
  endtask

  initial
  begin
    step(4);
    sys_rst_i = 1'b0;
    step();
    check({lk.dev_txd, lk.rem_txd, ab, tr, pr}, 6'h3c);
    t_formats();
    t_buffer();
    t_dma();
    t_addr();
    t_div();
    t_fault();
    tally_and_finish();
  end
endmodule
`default_nettype wire
